// File: verilog/e1io_core.sv
// E1 data-side logic: transmit input handling, mode select, receive
// output formatting and loss-of-signal monitor.
// Assumes line pulses and the line-derived clock arrive already sliced.
`timescale 1ns/10ps
module e1io_core
    import e1io_pkg::*;
(
    // System clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Reference and mode pins
    input wire logic mclk_ref_in,
    input wire logic mode_select_in,
    input wire logic rx_edge_select,
    // Transmit side
    input wire logic tx_sample_clock,
    input wire logic tx_positive_in,
    input wire logic tx_negative_in,
    output logic line_tx_positive,
    output logic line_tx_negative,
    // Line receive pins
    input wire logic line_rx_positive,
    input wire logic line_rx_negative,
    input wire logic line_clock_in,
    // Receive outputs
    output logic rx_clock_out,
    output logic rx_positive_out,
    output logic rx_negative_out,
    // Status
    output logic signal_loss_flag,
    output logic host_mode_out,
    output logic hdb3_enable_out,
    output logic unipolar_out,
    output logic rx_slip_out
);
    // ========================================
    // Pin synchronisers: 0 ref, 1 mode, 2 pos, 3 neg, 4 line clk, 5 uni
    logic [5:0] s1_q, s2_q;
    logic [2:0] prev_q;
    logic tx_uni_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            prev_q <= '0;
        end else begin
            s1_q <= {tx_uni_q, line_clock_in, line_rx_negative,
                     line_rx_positive, mode_select_in, mclk_ref_in};
            s2_q <= s1_q;
            prev_q <= {s2_q[4], s2_q[1], s2_q[0]};
        end
    end

    logic mclk_rise, mode_edge, lclk_rise, bit_str, rp, rn, mark;
    always_comb begin
        mclk_rise = s2_q[0] && !prev_q[0];
        mode_edge = s2_q[1] ^ prev_q[1];
        lclk_rise = s2_q[4] && !prev_q[2];
        bit_str = signal_loss_flag ? mclk_rise : lclk_rise;
        rp = s2_q[2];
        rn = s2_q[3];
        mark = rp || rn;
    end

    // ========================================
    // Mode detection
    // A static level cannot make edges, so two or more edges in one
    // window can only mean the pin follows the receive clock.
    e1io_mode_e mode_q, mode_d;
    logic [6:0] mwc_q, mwc_d;
    logic [2:0] tog_q, tog_d;
    logic win_end, tog_many;

    always_comb begin
        win_end = mwc_q == MODE_WIN_LAST;
        tog_many = tog_q >= MODE_MIN_TOGGLES;
        mode_d = mode_q;
        mwc_d = win_end ? '0 : mwc_q + 1'b1;
        tog_d = (mode_edge && tog_q != 3'h7) ? tog_q + 1'b1 : tog_q;
        if (win_end) begin
            tog_d = '0;
            if (tog_many) begin
                mode_d = MODE_HW_HDB3;
            end else if (s2_q[1]) begin
                mode_d = MODE_HOST;
            end else begin
                mode_d = MODE_HW;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= MODE_RESET;
            mwc_q <= '0;
            tog_q <= '0;
            host_mode_out <= 1'b0;
            hdb3_enable_out <= 1'b0;
        end else begin
            mode_q <= mode_d;
            mwc_q <= mwc_d;
            tog_q <= tog_d;
            host_mode_out <= mode_d == MODE_HOST;
            hdb3_enable_out <= mode_d == MODE_HW_HDB3;
        end
    end

    // ========================================
    // Receive decode
    logic last_pol_q, last_pol_d, viol, hdb3;
    logic [3:0] pd_q, pd_d, bv_q, bv_d;
    e1io_rxw_s push_w;

    always_comb begin
        hdb3 = mode_q == MODE_HW_HDB3;
        viol = mark && (rp == last_pol_q);
        pd_d = pd_q;
        bv_d = bv_q;
        last_pol_d = last_pol_q;
        if (bit_str) begin
            pd_d = {pd_q[2:0], mark && !(hdb3 && viol)};
            bv_d = {bv_q[2:0], viol && !hdb3};
            // Substituted pulse of a B00V group sits three bits back
            if (hdb3 && viol) begin
                pd_d[3] = 1'b0;
            end
            if (mark) begin
                last_pol_d = rp;
            end
        end
        if (s2_q[5]) begin
            push_w = '{pos: pd_d[3], neg: bv_d[3]};
        end else begin
            push_w = '{pos: rp, neg: rn};
        end
    end

    // ========================================
    // Loss of signal monitor
    logic [7:0] zr_q, zr_d;
    logic [4:0] wc_q, wc_d;
    logic [2:0] wm_q, wm_d;
    logic wb_q, wb_d, los_d;

    always_comb begin
        zr_d = zr_q;
        wc_d = wc_q;
        wm_d = wm_q;
        wb_d = wb_q;
        los_d = signal_loss_flag;
        if (bit_str) begin
            if (mark) begin
                zr_d = '0;
            end else if (zr_q != LOS_SET_SPACES) begin
                zr_d = zr_q + 1'b1;
            end
            wc_d = wc_q + 1'b1;
            if (mark && wm_q < LOS_MIN_MARKS) begin
                wm_d = wm_q + 1'b1;
            end
            wb_d = wb_q || (zr_d > LOS_MAX_ZEROS);
            if (wc_q == LOS_WIN_LAST) begin
                if (wm_d >= LOS_MIN_MARKS && !wb_d) begin
                    los_d = 1'b0;
                end
                wm_d = '0;
                wb_d = 1'b0;
            end
            if (zr_d == LOS_SET_SPACES) begin
                los_d = 1'b1;
            end
        end
    end

    // ========================================
    // Receive buffer and output timing
    // The buffer absorbs line jitter; an underrun halts output and
    // waits for a half-full buffer, trading latency for smoothness.
    logic f_in_ready, f_out_valid, f_out_ready, fall_valid, upd, fall;
    logic [5:0] f_level;
    e1io_rxw_s f_out;
    logic [4:0] ph_q, ph_d;
    logic run_q, run_d, clk_d, rx_positive_out_d, rx_negative_out_d, slip_d;

    e1io_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(bit_str),
        .in_ready(f_in_ready),
        .in_data(push_w),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out),
        .level(f_level)
    );

    always_comb begin
        fall_valid = host_mode_out && rx_edge_select;
        fall = !bit_str && (ph_q == HALF_LAST - 5'h1);
        // Rising-valid data changes at the falling edge
        upd = fall_valid ? bit_str : fall;
        f_out_ready = run_q && upd;
        ph_d = ph_q;
        clk_d = rx_clock_out;
        if (bit_str) begin
            ph_d = '0;
            clk_d = 1'b1;
        end else if (ph_q != HALF_LAST) begin
            ph_d = ph_q + 1'b1;
            if (fall) begin
                clk_d = 1'b0;
            end
        end
        run_d = run_q;
        if (!run_q && f_level >= FIFO_START) begin
            run_d = 1'b1;
        end else if (run_q && upd && !f_out_valid) begin
            run_d = 1'b0;
        end
        rx_positive_out_d = rx_positive_out;
        rx_negative_out_d = rx_negative_out;
        if (f_out_ready && f_out_valid) begin
            rx_positive_out_d = f_out.pos;
            rx_negative_out_d = f_out.neg;
        end
        slip_d = bit_str && !f_in_ready;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pol_q <= 1'b0;
            pd_q <= '0;
            bv_q <= '0;
            zr_q <= '0;
            wc_q <= '0;
            wm_q <= '0;
            wb_q <= 1'b0;
            signal_loss_flag <= 1'b0;
            ph_q <= HALF_LAST;
            run_q <= 1'b0;
            rx_clock_out <= 1'b0;
            rx_positive_out <= 1'b0;
            rx_negative_out <= 1'b0;
            rx_slip_out <= 1'b0;
            unipolar_out <= 1'b0;
        end else begin
            last_pol_q <= last_pol_d;
            pd_q <= pd_d;
            bv_q <= bv_d;
            zr_q <= zr_d;
            wc_q <= wc_d;
            wm_q <= wm_d;
            wb_q <= wb_d;
            signal_loss_flag <= los_d;
            ph_q <= ph_d;
            run_q <= run_d;
            rx_clock_out <= clk_d;
            rx_positive_out <= rx_positive_out_d;
            rx_negative_out <= rx_negative_out_d;
            rx_slip_out <= slip_d;
            unipolar_out <= s2_q[5];
        end
    end

    // ========================================
    // Transmit side, on the falling edge of the transmit clock
    logic hs1_q, hs2_q;
    logic [4:0] tx_hi_q, tx_hi_d;
    logic tx_uni_d, par_q, par_d, tpol_q, tpol_d, tmark, tpol;
    logic ltp_d, ltn_d;
    e1io_sym_e [3:0] txq_q, txq_d;
    e1io_sym_e new_sym;

    always_comb begin
        tx_hi_d = '0;
        if (tx_negative_in) begin
            tx_hi_d = (tx_hi_q == UNI_HIGH_CYCLES) ? tx_hi_q : tx_hi_q + 1'b1;
        end
        tx_uni_d = tx_negative_in && (tx_uni_q ||
                   tx_hi_d == UNI_HIGH_CYCLES);
        new_sym = tx_positive_in ? SYM_ONE : SYM_ZERO;
        txq_d = '{txq_q[2], txq_q[1], txq_q[0], new_sym};
        par_d = tx_positive_in ? !par_q : par_q;
        // Four zeros in a row become 000V or B00V
        if (hs2_q && !tx_positive_in && txq_q[0] == SYM_ZERO &&
                txq_q[1] == SYM_ZERO && txq_q[2] == SYM_ZERO) begin
            txq_d[0] = SYM_V;
            if (!par_q) begin
                txq_d[3] = SYM_B;
            end
            par_d = 1'b0;
        end
        tmark = txq_q[3] != SYM_ZERO;
        tpol = (txq_q[3] == SYM_V) ? tpol_q : !tpol_q;
        tpol_d = tmark ? tpol : tpol_q;
        if (tx_uni_q) begin
            ltp_d = tmark && tpol;
            ltn_d = tmark && !tpol;
        end else begin
            ltp_d = tx_positive_in;
            ltn_d = tx_negative_in;
        end
    end

    always_ff @(negedge tx_sample_clock or negedge rst_n) begin
        if (!rst_n) begin
            hs1_q <= 1'b0;
            hs2_q <= 1'b0;
            tx_hi_q <= '0;
            tx_uni_q <= 1'b0;
            par_q <= 1'b0;
            tpol_q <= 1'b0;
            txq_q <= '{default: SYM_ZERO};
            line_tx_positive <= 1'b0;
            line_tx_negative <= 1'b0;
        end else begin
            hs1_q <= hdb3_enable_out;
            hs2_q <= hs1_q;
            tx_hi_q <= tx_hi_d;
            tx_uni_q <= tx_uni_d;
            par_q <= par_d;
            tpol_q <= tpol_d;
            txq_q <= txq_d;
            line_tx_positive <= ltp_d;
            line_tx_negative <= ltn_d;
        end
    end

    // ========================================
    // Checks
    sequence neg_held_s;
        tx_negative_in && tx_hi_q == UNI_HIGH_CYCLES - 5'h1;
    endsequence

    sequence toggle_win_s;
        win_end ##0 tog_many;
    endsequence

    uni_enter_a: assert property (@(negedge tx_sample_clock)
        disable iff (!rst_n) neg_held_s |=> tx_uni_q)
        else $error("unipolar not entered after 16 high clocks");

    uni_early_a: assert property (@(negedge tx_sample_clock)
        disable iff (!rst_n) $rose(tx_uni_q) |-> $past(tx_hi_q) ==
            UNI_HIGH_CYCLES - 5'h1)
        else $error("unipolar entered too early");

    tx_bipolar_a: assert property (@(negedge tx_sample_clock)
        disable iff (!rst_n) (!tx_uni_q ##1 !tx_uni_q) |->
            line_tx_positive == $past(tx_positive_in) &&
            line_tx_negative == $past(tx_negative_in))
        else $error("bipolar transmit not sampled on falling edge");

    los_set_a: assert property (@(posedge clk)
        disable iff (!rst_n) (bit_str && !mark &&
            zr_q == LOS_SET_SPACES - 8'h1) |=> signal_loss_flag)
        else $error("loss of signal not raised at 175 spaces");

    los_clock_a: assert property (@(posedge clk)
        disable iff (!rst_n) (signal_loss_flag && mclk_rise) |=>
            rx_clock_out [*2])
        else $error("receive clock not following master during loss");

    hw_edge_a: assert property (@(posedge clk)
        disable iff (!rst_n) (!host_mode_out && $past(!host_mode_out) &&
            $changed(rx_positive_out)) |-> !rx_clock_out)
        else $error("hardware mode data changed while clock high");

    host_edge_a: assert property (@(posedge clk)
        disable iff (!rst_n) ($past(fall_valid) && fall_valid &&
            $changed(rx_positive_out)) |-> $rose(rx_clock_out))
        else $error("falling-edge data not changed at rising edge");

    mode_hdb3_a: assert property (@(posedge clk)
        disable iff (!rst_n) toggle_win_s |=>
            hdb3_enable_out && !host_mode_out)
        else $error("toggling mode pin did not enable line code");

    mode_level_a: assert property (@(posedge clk)
        disable iff (!rst_n) (win_end && !tog_many) |=>
            host_mode_out == $past(s2_q[1]) && !hdb3_enable_out)
        else $error("static mode level not decoded");
endmodule

// File: verilog/e1io_pkg.sv
// Constants, types and layouts shared by the E1 data-side block.
// Assumes a 40 MHz system clock and a 2.048 Mbit/s line.
//
// What this block does
// - Receive and mode timing run on the system clock; the 2.048 MHz master reference times bits only during loss of signal.
// - While loss of signal stands, the receive clock follows the master.
// - Transmit data inputs are sampled on the falling transmit clock edge.
// - The negative input high for 16 transmit clocks selects unipolar.
// - A high mode input selects host mode with the serial port active.
// - A low mode input selects hardware mode with the serial port off.
// - A mode input toggling at clock rate gives hardware mode plus HDB3.
// - In bipolar mode each line pulse shows on its own receive output.
// - In host mode the edge select picks the edge receive data is valid.
// - In hardware mode receive data is valid on the rising clock edge.
// - In unipolar mode without HDB3 the negative output flags bipolar violations.
// - Loss of signal rises after 175 spaces, falls at 4 marks in 32 bits.
// - Received marks still reach the outputs while loss of signal stands.
package e1io_pkg;
    // ========================================
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int MCLK_KHZ = 2048;
    localparam int HALF_BIT_NS = 244;
    localparam int HALF_BIT_CYC = (HALF_BIT_NS / CLK_PERIOD_NS < 1) ? 1 :
        HALF_BIT_NS / CLK_PERIOD_NS;
    localparam logic [4:0] HALF_LAST = 5'(HALF_BIT_CYC);
    localparam int MODE_WIN_NS = 1600;
    localparam int MODE_WIN_CYC = MODE_WIN_NS / CLK_PERIOD_NS;
    localparam logic [6:0] MODE_WIN_LAST = 7'(MODE_WIN_CYC - 1);
    localparam logic [2:0] MODE_MIN_TOGGLES = 3'h2;
    // ========================================
    // Line code limits
    localparam logic [4:0] UNI_HIGH_CYCLES = 5'h10;
    localparam logic [7:0] LOS_SET_SPACES = 8'haf;
    localparam logic [7:0] LOS_MAX_ZEROS = 8'h0f;
    localparam logic [4:0] LOS_WIN_LAST = 5'h1f;
    localparam logic [2:0] LOS_MIN_MARKS = 3'h4;
    // ========================================
    // Receive buffer
    localparam int FIFO_WIDTH = 2;
    localparam int FIFO_DEPTH = 32;
    localparam logic [5:0] FIFO_START = 6'h10;
    // ========================================
    // Types
    typedef enum logic [1:0] {MODE_HW, MODE_HOST, MODE_HW_HDB3} e1io_mode_e;
    typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_B, SYM_V} e1io_sym_e;
    typedef struct packed {
        logic pos;
        logic neg;
    } e1io_rxw_s;
    localparam e1io_mode_e MODE_RESET = MODE_HW;
endpackage

// File: verilog/e1io_fifo.sv
// Elastic buffer between the line bit timing and the output clock.
// Assumes both sides run on the same clock.
`timescale 1ns/10ps
module e1io_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q, wr_d, rd_q, rd_d;
    logic push, pop;

    // ========================================
    // Pointers
    always_comb begin
        in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
        out_valid = wr_q != rd_q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        out_data = mem_q[rd_q[AW-1:0]];
        level = wr_q - rd_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
        end
    end

    // No reset on storage; words are only read once written
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// File: test/e1io_tx_framer.sv
// Framer model on the transmit side: makes the transmit clock and data.
// Assumes the block samples both data pins on the falling clock edge.
`timescale 1ns/10ps
module e1io_tx_framer (
    // Transmit link
    output logic tx_sample_clock,
    output logic tx_positive_in,
    output logic tx_negative_in
);
    // ========================================
    // Idle levels
    initial begin
        tx_sample_clock = 1'b0;
        tx_positive_in = 1'b0;
        tx_negative_in = 1'b0;
    end
    // ========================================
    // One bit a call; clock stands still between calls
    task automatic send_bit(input logic pos, input logic neg);
        // Hold time over, so old data is not left showing
        tx_positive_in = ~tx_positive_in;
        tx_negative_in = ~tx_negative_in;
        #12;
        tx_sample_clock = 1'b1;
        #1;
        tx_positive_in = pos;
        tx_negative_in = neg;
        #15;
        tx_sample_clock = 1'b0;
        #4;
    endtask
endmodule

// File: test/tb.sv
// Bench for the E1 data-side block: mode, transmit and receive paths.
// Assumes the framer model drives the transmit pins and clock.
`timescale 1ns/10ps
module tb;
    // ========================================
    // Pins and bench state
    logic clk, rst_n = 1'b0, mclk_ref_in = 1'b0, mode_select_in = 1'b0;
    logic rx_edge_select = 1'b0, line_clock_in = 1'b0;
    logic line_rx_positive = 1'b0, line_rx_negative = 1'b0;
    logic tx_sample_clock, tx_positive_in, tx_negative_in;
    logic line_tx_positive, line_tx_negative, rx_clock_out, rx_positive_out;
    logic rx_negative_out, signal_loss_flag, host_mode_out, hdb3_enable_out;
    logic unipolar_out, rx_slip_out, prev_p;
    logic line_on = 1'b0, mode_tie = 1'b0, mode_lvl = 1'b0;
    int acc_q = 0, idx_q = 0, pat_sel = 0, num_errors = 0, total_checks = 0;
    int np, nn, mv, ed, slips = 0;

    e1io_tx_framer u_e1io_tx_framer (
        .tx_sample_clock(tx_sample_clock),
        .tx_positive_in(tx_positive_in),
        .tx_negative_in(tx_negative_in)
    );
    e1io_core u_e1io_core (
        .clk(clk),
        .rst_n(rst_n),
        .mclk_ref_in(mclk_ref_in),
        .mode_select_in(mode_select_in),
        .rx_edge_select(rx_edge_select),
        .tx_sample_clock(tx_sample_clock),
        .tx_positive_in(tx_positive_in),
        .tx_negative_in(tx_negative_in),
        .line_tx_positive(line_tx_positive),
        .line_tx_negative(line_tx_negative),
        .line_rx_positive(line_rx_positive),
        .line_rx_negative(line_rx_negative),
        .line_clock_in(line_clock_in),
        .rx_clock_out(rx_clock_out),
        .rx_positive_out(rx_positive_out),
        .rx_negative_out(rx_negative_out),
        .signal_loss_flag(signal_loss_flag),
        .host_mode_out(host_mode_out),
        .hdb3_enable_out(hdb3_enable_out),
        .unipolar_out(unipolar_out),
        .rx_slip_out(rx_slip_out)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ========================================
    // Line patterns as {pos, neg}; 88 bits covers every period
    function automatic logic [1:0] pat_bit(input int sel, input int i);
        case (sel)
            1: return (i % 4 == 3) ? 2'h1 : (i % 4 == 2) ? 2'h0 : 2'h2;
            2: return (i % 8 == 2) ? 2'h1 : (i % 2 == 0) ? 2'h2 : 2'h0;
            3: return (i % 22 == 0) ? 2'h2 : (i % 22 == 11) ? 2'h1 : 2'h0;
            default: return 2'h0;
        endcase
    endfunction

    // Phase accumulator keeps the exact average rate on a 40 MHz grid
    always @(posedge clk) begin
        if (acc_q + 4096 >= 40000) begin
            acc_q <= acc_q + 4096 - 40000;
            mclk_ref_in <= ~mclk_ref_in;
            line_clock_in <= ~mclk_ref_in & line_on;
            if (mclk_ref_in) begin
                idx_q <= (idx_q + 1) % 88;
                {line_rx_positive, line_rx_negative} <= pat_bit(pat_sel, idx_q);
            end
        end else begin
            acc_q <= acc_q + 4096;
        end
        mode_select_in <= mode_tie ? rx_clock_out : mode_lvl;
    end

    // ========================================
    // Compare, wait and verdict
    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_cnt(input string what, input int exp, input int got);
        total_checks++;
        if (got != exp) begin
            num_errors++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic bits(input int n);
        repeat (n) @(posedge mclk_ref_in);
        wait_clk(8);
    endtask

    // Counts marks at the chosen output clock edge, after a warm-up of 40
    // edges, and how often data moved in the same cycle as that edge
    task automatic rx_scan(input logic fall, output int p, output int n,
                           output int moved, output int edges);
        int cyc = 0;
        logic ck0;
        logic [1:0] old;
        p = 0;
        n = 0;
        moved = 0;
        edges = 0;
        @(posedge clk);
        #1;
        ck0 = rx_clock_out;
        old = {rx_positive_out, rx_negative_out};
        while (edges < 104 && cyc < 5000) begin
            @(posedge clk);
            #1;
            cyc++;
            slips += (rx_slip_out !== 1'b0);
            if (ck0 !== rx_clock_out && rx_clock_out === !fall) begin
                edges++;
                if (edges > 40) begin
                    p += (rx_positive_out === 1'b1);
                    n += (rx_negative_out === 1'b1);
                    moved += ({rx_positive_out, rx_negative_out} !== old);
                end
            end
            ck0 = rx_clock_out;
            old = {rx_positive_out, rx_negative_out};
        end
    endtask

    // ========================================
    // Watchdog
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end

    // ========================================
    // Main sequence
    initial begin
        fork
            repeat (4) @(posedge clk);
            repeat (2) u_e1io_tx_framer.send_bit(1'b0, 1'b0);
        join
        rst_n <= 1'b1;
        wait_clk(2);
        check_bit("signal loss", 1'b0, signal_loss_flag);
        check_bit("host mode", 1'b0, host_mode_out);
        check_bit("line tx pos", 1'b0, line_tx_positive);
        // Hardware mode ignores the edge select
        @(posedge clk);
        line_on <= 1'b1;
        pat_sel <= 1;
        rx_edge_select <= 1'b1;
        rx_scan(1'b0, np, nn, mv, ed);
        check_cnt("rx pos marks", 32, np);
        check_cnt("rx neg marks", 16, nn);
        check_cnt("rx moves at rise", 0, mv);
        @(posedge clk);
        mode_lvl <= 1'b1;
        wait_clk(200);
        check_bit("host mode", 1'b1, host_mode_out);
        check_bit("hdb3 enable", 1'b0, hdb3_enable_out);
        rx_scan(1'b1, np, nn, mv, ed);
        check_cnt("rx moves at fall", 0, mv);
        check_cnt("rx pos marks", 32, np);
        @(posedge clk);
        mode_lvl <= 1'b0;
        wait_clk(200);
        check_bit("host mode", 1'b0, host_mode_out);
        check_bit("hdb3 enable", 1'b0, hdb3_enable_out);
        // Last bit low, so no run of high negative samples carries on
        for (int i = 3; i >= 0; i--) begin
            u_e1io_tx_framer.send_bit(i[0], i[1]);
            check_bit("line tx pos", i[0], line_tx_positive);
            check_bit("line tx neg", i[1], line_tx_negative);
        end
        repeat (15) u_e1io_tx_framer.send_bit(1'b0, 1'b1);
        u_e1io_tx_framer.send_bit(1'b0, 1'b0);
        wait_clk(10);
        check_bit("unipolar at 15", 1'b0, unipolar_out);
        repeat (16) u_e1io_tx_framer.send_bit(1'b0, 1'b1);
        wait_clk(10);
        check_bit("unipolar at 16", 1'b1, unipolar_out);
        for (int i = 1; i <= 8; i++) begin
            u_e1io_tx_framer.send_bit(1'b1, 1'b1);
            if (i >= 5) begin
                check_bit("tx one mark", 1'b1,
                          line_tx_positive ^ line_tx_negative);
                if (i >= 6) check_bit("tx alternates", 1'b1,
                                      line_tx_positive ^ prev_p);
                prev_p = line_tx_positive;
            end
        end
        @(posedge clk);
        pat_sel <= 2;
        rx_scan(1'b0, np, nn, mv, ed);
        check_cnt("rx unipolar data", 32, np);
        check_cnt("rx violations", 16, nn);
        u_e1io_tx_framer.send_bit(1'b0, 1'b0);
        wait_clk(10);
        check_bit("unipolar left", 1'b0, unipolar_out);
        // Loss of signal: set, clock from reference, sparse marks, clear
        @(posedge clk);
        pat_sel <= 0;
        bits(170);
        check_bit("loss before 175", 1'b0, signal_loss_flag);
        bits(10);
        check_bit("loss after 175", 1'b1, signal_loss_flag);
        @(posedge clk);
        line_on <= 1'b0;
        rx_scan(1'b0, np, nn, mv, ed);
        check_cnt("rx clock edges", 104, ed);
        @(posedge clk);
        line_on <= 1'b1;
        pat_sel <= 3;
        rx_scan(1'b0, np, nn, mv, ed);
        check_bit("marks in loss", 1'b1, (np + nn) > 0);
        check_bit("loss at 3 marks", 1'b1, signal_loss_flag);
        @(posedge clk);
        pat_sel <= 1;
        bits(100);
        check_bit("loss cleared", 1'b0, signal_loss_flag);
        @(posedge clk);
        mode_tie <= 1'b1;
        wait_clk(200);
        check_bit("hdb3 enable", 1'b1, hdb3_enable_out);
        check_bit("host mode", 1'b0, host_mode_out);
        // Zeros in unipolar mode must now carry substituted pulses
        repeat (16) u_e1io_tx_framer.send_bit(1'b0, 1'b1);
        ed = 0;
        repeat (8) begin
            u_e1io_tx_framer.send_bit(1'b0, 1'b1);
            ed += (line_tx_positive | line_tx_negative);
        end
        check_bit("hdb3 zero fill", 1'b1, ed >= 2);
        check_cnt("rx slips", 0, slips);
        give_verdict();
    end
endmodule
